// ==== setup_filter_defines.vh ====
/*
 setup filter constants: register addresses, field positions, reset values,
 command codes and token pid values.
 assumes a 16-bit register address space on the microcontroller side.
*/
`ifndef SETUP_FILTER_DEFINES_VH
`define SETUP_FILTER_DEFINES_VH

`define ADDR_ENDPOINT_COMMAND 16'h7FAA
`define ADDR_SETUP_MASK_HIGH 16'h7FAB
`define ADDR_SETUP_MASK_LOW 16'h7FAC

`define RESET_ENDPOINT_COMMAND 8'h00
`define RESET_SETUP_MASK 8'h00

`define CMD_DIR_BIT 7
`define CMD_CODE_HI 6
`define CMD_CODE_LO 4
`define CMD_EP_HI 3
`define CMD_EP_LO 0

`define CMD_DISABLE 3'h0
`define CMD_STALL 3'h1
`define CMD_NORMAL 3'h2
`define CMD_NAK 3'h3
`define CMD_TOGGLE_CLR 3'h4
`define CMD_TOGGLE_SET 3'h5
`define CMD_ISO_CLR 3'h6
`define CMD_ISO_SET 3'h7

`define MODE_DISABLED 2'h0
`define MODE_STALL 2'h1
`define MODE_NORMAL 2'h2
`define MODE_NAK 2'h3

`define PID_SETUP 4'hD

`endif

// ==== endpoint_state_bank.v ====
/*
 per-endpoint, per-direction control state: handshake mode, toggle and
 isochronous flag, updated by one decoded command at a time.
 assumes the command pulse is one cycle and comes from the register block.
*/
`timescale 1ns/1ps
`include "setup_filter_defines.vh"

module endpoint_state_bank (
   // clock and reset
   input wire sys_clk,
   input wire rstn,
   // command
   input wire cmd_valid,
   input wire cmd_dir_tx,
   input wire [2:0] cmd_code,
   input wire [3:0] cmd_ep,
   // flattened state, endpoint n at bits [2n+1:2n] and bit n
   output wire [31:0] tx_mode,
   output wire [31:0] rx_mode,
   output wire [15:0] tx_toggle,
   output wire [15:0] rx_toggle,
   output wire [15:0] tx_iso,
   output wire [15:0] rx_iso
);

   genvar i;
   generate
      for (i = 0; i < 16; i = i + 1) begin : ep
         reg [1:0] tx_mode_q;
         reg [1:0] rx_mode_q;
         reg tx_tog_q;
         reg rx_tog_q;
         reg tx_iso_q;
         reg rx_iso_q;
         wire hit_tx;
         wire hit_rx;
         // only the selected endpoint moves
         assign hit_tx = cmd_valid && cmd_ep == i && cmd_dir_tx;
         assign hit_rx = cmd_valid && cmd_ep == i && !cmd_dir_tx;
         always @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               tx_mode_q <= `MODE_DISABLED;
               rx_mode_q <= `MODE_DISABLED;
               tx_tog_q <= 1'b0;
               rx_tog_q <= 1'b0;
               tx_iso_q <= 1'b0;
               rx_iso_q <= 1'b0;
            end else begin
               // codes 0..3 map straight onto the handshake mode
               if (hit_tx && !cmd_code[2])
                  tx_mode_q <= cmd_code[1:0];
               if (hit_rx && !cmd_code[2])
                  rx_mode_q <= cmd_code[1:0];
               if (hit_tx && cmd_code[2:1] == 2'b10)
                  tx_tog_q <= cmd_code[0];
               if (hit_rx && cmd_code[2:1] == 2'b10)
                  rx_tog_q <= cmd_code[0];
               if (hit_tx && cmd_code[2:1] == 2'b11)
                  tx_iso_q <= cmd_code[0];
               if (hit_rx && cmd_code[2:1] == 2'b11)
                  rx_iso_q <= cmd_code[0];
            end
         end
         assign tx_mode[2*i+1:2*i] = tx_mode_q;
         assign rx_mode[2*i+1:2*i] = rx_mode_q;
         assign tx_toggle[i] = tx_tog_q;
         assign rx_toggle[i] = rx_tog_q;
         assign tx_iso[i] = tx_iso_q;
         assign rx_iso[i] = rx_iso_q;
      end
   endgenerate

endmodule

// ==== setup_token_endpoint_filter.v ====
/*
 setup token filter with the endpoint command register and the two
 setup ignore mask registers.
 assumes the token decoder runs on sys_clk and gives one-cycle token pulses
 with pid and endpoint; the handshake engine acts on the verdict outputs.
*/
// Our own choice: the plain strobed port.
// Behaviour
// - a setup to a masked endpoint is dropped whole: no handshake, no data kept.
// - a mask bit of one suppresses the reply to setup for that endpoint.
// - a mask bit of zero lets setup through as a normal control transfer.
// - only the mask bit of the addressed endpoint is consulted.
// - the high mask at 0x7FAB holds endpoints fifteen to eight, bit 7 to 0.
// - the low mask at 0x7FAC holds endpoints seven to zero, bit 7 to 0.
// - command bit 7 picks the transmit side when one, receive when zero.
// - command bits 6:4 pick disable, stall, normal, nak, toggle and iso ops.
`timescale 1ns/1ps
`include "setup_filter_defines.vh"

module setup_token_endpoint_filter (
   // clock and reset
   input wire sys_clk,
   input wire rstn,
   // register port
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   // token from decoder
   input wire token_valid,
   input wire [3:0] token_pid,
   input wire [3:0] token_ep,
   // verdict to handshake engine
   output reg setup_accept,
   output reg setup_drop,
   output reg [3:0] verdict_ep,
   // endpoint state of the token's endpoint
   output reg [1:0] tx_mode_sel,
   output reg [1:0] rx_mode_sel,
   output reg tx_toggle_sel,
   output reg rx_toggle_sel,
   output reg tx_iso_sel,
   output reg rx_iso_sel,
   // per-endpoint masks for the data path
   output reg [15:0] setup_ignore_mask
);

   reg [7:0] endpoint_command_q;
   reg [7:0] mask_high_q;
   reg [7:0] mask_low_q;
   reg cmd_valid_q;
   wire [15:0] mask_all;
   wire mask_hit;
   wire is_setup;
   wire [31:0] tx_mode;
   wire [31:0] rx_mode;
   wire [15:0] tx_toggle;
   wire [15:0] rx_toggle;
   wire [15:0] tx_iso;
   wire [15:0] rx_iso;

   // registers; a write to the command register also fires the command
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         endpoint_command_q <= `RESET_ENDPOINT_COMMAND;
         mask_high_q <= `RESET_SETUP_MASK;
         mask_low_q <= `RESET_SETUP_MASK;
         cmd_valid_q <= 1'b0;
      end else begin
         cmd_valid_q <= reg_wr && reg_addr == `ADDR_ENDPOINT_COMMAND;
         if (reg_wr && reg_addr == `ADDR_ENDPOINT_COMMAND)
            endpoint_command_q <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_SETUP_MASK_HIGH)
            mask_high_q <= reg_wdata;
         if (reg_wr && reg_addr == `ADDR_SETUP_MASK_LOW)
            mask_low_q <= reg_wdata;
      end
   end

   // read data in the cycle after the strobe; unmapped reads give zero
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `ADDR_ENDPOINT_COMMAND: reg_rdata <= endpoint_command_q;
            `ADDR_SETUP_MASK_HIGH: reg_rdata <= mask_high_q;
            `ADDR_SETUP_MASK_LOW: reg_rdata <= mask_low_q;
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // high register is endpoints 15..8, low is 7..0
   assign mask_all = {mask_high_q, mask_low_q};
   assign mask_hit = mask_all[token_ep];
   assign is_setup = token_valid && token_pid == `PID_SETUP;

   endpoint_state_bank u_state (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .cmd_valid(cmd_valid_q),
      .cmd_dir_tx(endpoint_command_q[`CMD_DIR_BIT]),
      .cmd_code(endpoint_command_q[`CMD_CODE_HI:`CMD_CODE_LO]),
      .cmd_ep(endpoint_command_q[`CMD_EP_HI:`CMD_EP_LO]),
      .tx_mode(tx_mode),
      .rx_mode(rx_mode),
      .tx_toggle(tx_toggle),
      .rx_toggle(rx_toggle),
      .tx_iso(tx_iso),
      .rx_iso(rx_iso)
   );

   // verdict registered one cycle after the token; a drop means the
   // handshake engine must neither reply nor store the data packet
   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         setup_accept <= 1'b0;
         setup_drop <= 1'b0;
         verdict_ep <= 4'h0;
         tx_mode_sel <= `MODE_DISABLED;
         rx_mode_sel <= `MODE_DISABLED;
         tx_toggle_sel <= 1'b0;
         rx_toggle_sel <= 1'b0;
         tx_iso_sel <= 1'b0;
         rx_iso_sel <= 1'b0;
         setup_ignore_mask <= 16'h0000;
      end else begin
         setup_drop <= is_setup && mask_hit;
         setup_accept <= is_setup && !mask_hit;
         if (token_valid) begin
            verdict_ep <= token_ep;
            tx_mode_sel <= tx_mode[{token_ep, 1'b0} +: 2];
            rx_mode_sel <= rx_mode[{token_ep, 1'b0} +: 2];
            tx_toggle_sel <= tx_toggle[token_ep];
            rx_toggle_sel <= rx_toggle[token_ep];
            tx_iso_sel <= tx_iso[token_ep];
            rx_iso_sel <= rx_iso[token_ep];
         end
         setup_ignore_mask <= mask_all;
      end
   end

endmodule

// ==== setup_filter_sva.sv ====
/* checker: setup verdicts, read port, mask copy.
 assumes one clock and a low reset; bound to the filter. */
`timescale 1ns/1ps
`include "setup_filter_defines.vh"
module setup_filter_sva (
   // clock and reset
   input wire sys_clk, rstn,
   // register port
   input wire [15:0] reg_addr,
   input wire [7:0] reg_wdata, reg_rdata,
   input wire reg_wr, reg_rd,
   // token and verdict
   input wire token_valid, setup_accept, setup_drop,
   input wire [3:0] token_pid, token_ep, verdict_ep,
   input wire [15:0] setup_ignore_mask
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire st = token_valid && token_pid == `PID_SETUP;
   // mask copy lags a cycle, so skip tokens just after a write
   a_drop_masked:
   assert property (st && !$past(reg_wr) && setup_ignore_mask[token_ep]
      |=> setup_drop && !setup_accept) else $error("no drop");
   a_accept_clear:
   assert property (st && !$past(reg_wr) && !setup_ignore_mask[token_ep]
      |=> setup_accept && !setup_drop) else $error("no accept");
   a_other_quiet:
   assert property (!st |=> !setup_accept && !setup_drop)
      else $error("stray verdict");
   a_verdict_ep:
   assert property (token_valid |=> verdict_ep == $past(token_ep))
      else $error("bad verdict ep");
   a_rdata_idle:
   assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("rdata");
   a_unmapped_zero:
   assert property (reg_rd && reg_addr == 16'h7FAD |=> reg_rdata == 8'h00)
      else $error("unmapped read");
   a_mask_high:
   assert property (reg_wr && reg_addr == `ADDR_SETUP_MASK_HIGH ##1 !reg_wr
      |=> setup_ignore_mask[15:8] == $past(reg_wdata, 2)) else $error("hi");
   a_mask_low:
   assert property (reg_wr && reg_addr == `ADDR_SETUP_MASK_LOW ##1 !reg_wr
      |=> setup_ignore_mask[7:0] == $past(reg_wdata, 2)) else $error("lo");
   c_drop: cover property (setup_drop);
   c_accept: cover property (setup_accept);
   c_cmd: cover property (reg_wr && reg_addr == `ADDR_ENDPOINT_COMMAND);
endmodule
bind setup_token_endpoint_filter setup_filter_sva i_setup_filter_sva (
   .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .token_valid(token_valid), .setup_accept(setup_accept),
   .setup_drop(setup_drop), .token_pid(token_pid), .token_ep(token_ep),
   .verdict_ep(verdict_ep), .setup_ignore_mask(setup_ignore_mask));

// ==== token_host.sv ====
/* host model: sends one-cycle tokens.
 assumes the bench calls send from its main process. */
`timescale 1ns/1ps
module token_host (
   input wire sys_clk,
   output reg token_valid = 1'b0,
   output reg [3:0] token_pid = 4'h0,
   output reg [3:0] token_ep = 4'h0
);
   task send(input [3:0] p, input [3:0] e);
      begin
         @(posedge sys_clk);
         token_valid <= 1'b1;
         token_pid <= p;
         token_ep <= e;
         @(posedge sys_clk);
         token_valid <= 1'b0;
         // idle lines inverted so stale values never pass
         token_pid <= ~p;
         token_ep <= ~e;
      end
   endtask
endmodule

// ==== setup_token_endpoint_filter_tb.sv ====
/* bench: mask registers, setup verdicts, endpoint commands.
 assumes the host model and the bound checker. */
`timescale 1ns/1ps
module setup_token_endpoint_filter_tb;
   reg sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   reg [15:0] reg_addr = 16'h0000;
   reg [7:0] reg_wdata = 8'h00;
   wire [7:0] rdata;
   wire tv, acc, drp, txt, rxt, txi, rxi;
   wire [3:0] pid, ep, vep;
   wire [1:0] txm, rxm;
   wire [15:0] msk;
   integer fails = 0, check_count = 0, cyc = 0, i;
   reg [15:0] m = 16'hA53C;
   token_host i_token_host (.sys_clk(sys_clk), .token_valid(tv),
      .token_pid(pid), .token_ep(ep));
   setup_token_endpoint_filter i_setup_token_endpoint_filter (
      .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(rdata), .token_valid(tv), .token_pid(pid), .token_ep(ep),
      .setup_accept(acc), .setup_drop(drp), .verdict_ep(vep),
      .tx_mode_sel(txm), .rx_mode_sel(rxm), .tx_toggle_sel(txt),
      .rx_toggle_sel(rxt), .tx_iso_sel(txi), .rx_iso_sel(rxi),
      .setup_ignore_mask(msk));
   initial forever #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 2000) begin
         fails = fails + 1;
         summarize;
      end
   end
   task chk(input [15:0] g, input [15:0] x);
      begin
         check_count = check_count + 1;
         if (g !== x) begin
            fails = fails + 1;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
         end
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      begin
         @(posedge sys_clk);
         reg_wr <= 1'b1;
         reg_addr <= a;
         reg_wdata <= d;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
   endtask
   task rd(input [15:0] a, input [7:0] x);
      begin
         @(posedge sys_clk);
         reg_rd <= 1'b1;
         reg_addr <= a;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         #1 chk(rdata, x);
      end
   endtask
   task tok(input [3:0] p, input [3:0] e, input [1:0] v);
      begin
         i_token_host.send(p, e);
         #1 chk({acc, drp}, v);
         chk(vep, e);
      end
   endtask
   task test_regs;
      begin
         for (i = 16'h7FAA; i < 16'h7FAE; i = i + 1)
            rd(i, 8'h00);
         wr(16'h7FAB, m[15:8]);
         wr(16'h7FAC, m[7:0]);
         wr(16'h7FAD, 8'hFF);
         rd(16'h7FAB, m[15:8]);
         rd(16'h7FAC, m[7:0]);
         rd(16'h7FAD, 8'h00);
         chk(msk, m);
         $display("test regs done");
      end
   endtask
   task test_setup;
      begin
         for (i = 0; i < 16; i = i + 1)
            tok(4'hD, i, m[i] ? 2'b01 : 2'b10);
         tok(4'h1, 4'h2, 2'b00);
         tok(4'h9, 4'h0, 2'b00);
         $display("test setup done");
      end
   endtask
   task test_cmd;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            wr(16'h7FAA, {1'b1, i[2:0], 4'h5});
            tok(4'h9, 4'h5, 2'b00);
            chk({txm, txt, txi, rxm}, {i < 4 ? i[1:0] : 2'h3,
               i > 4 ? 1'b1 : 1'b0, i == 7 ? 1'b1 : 1'b0, 2'h0});
         end
         wr(16'h7FAA, 8'h2A);
         rd(16'h7FAA, 8'h2A);
         tok(4'h9, 4'hA, 2'b00);
         chk({txm, rxm}, 4'h2);
         tok(4'h9, 4'h5, 2'b00);
         chk({txm, rxm}, 4'hC);
         // receive side toggle and iso on ep3, transmit side must stay put
         wr(16'h7FAA, 8'h53);
         wr(16'h7FAA, 8'h73);
         tok(4'h9, 4'h3, 2'b00);
         chk({rxm, rxt, rxi, txt, txi}, 6'h0C);
         wr(16'h7FAA, 8'h43);
         wr(16'h7FAA, 8'h63);
         tok(4'h9, 4'h3, 2'b00);
         chk({rxm, rxt, rxi, txt, txi}, 6'h00);
         $display("test cmd done");
      end
   endtask
   task test_reset;
      begin
         tok(4'hD, 4'h3, 2'b01);
         @(posedge sys_clk);
         rstn <= 1'b0;
         #1 chk(msk, 16'h0000);
         repeat (2) @(posedge sys_clk);
         rstn <= 1'b1;
         rd(16'h7FAC, 8'h00);
         rd(16'h7FAB, 8'h00);
         tok(4'hD, 4'h3, 2'b10);
         $display("test reset done");
      end
   endtask
   task summarize;
      begin
         $display("checks %0d mismatches %0d", check_count, fails);
         if (fails == 0 && check_count > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      test_regs;
      test_setup;
      test_cmd;
      test_reset;
      summarize;
   end
endmodule
